// *** bench/tb.sv ***
/*
 Self-checking bench for the timer channel.
 Assumes the register offsets and mode layout of the package.
*/
module tb
   import tcmo_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, pin_in, mirq, pin_out, irq;
   logic [5:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, rs;
   logic [2:0]  trg [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
   int          n_fail, checks, cyc, d, n;
   longint      t1;

   tcmo_channel dut_u (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
      .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
      .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
      .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
      .rready(rready), .rdata(rdata), .rresp(rresp), .timer_input_pin(pin_in),
      .master_irq(mirq), .timer_output_pin(pin_out), .irq(irq));
   tcmo_pins_model pins_u (.aclk(aclk), .timer_input_pin(pin_in), .master_irq(mirq),
      .timer_output_pin(pin_out));

   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end

   task automatic give_verdict();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         n_fail++;
         give_verdict();
      end
   end

   task automatic check(input string what, input logic [31:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [5:0] a, input logic [31:0] v);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (awvalid && !awready || wvalid && !wready);
      do @(posedge aclk); while (!bvalid);
      bready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic rdr(input logic [5:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      while (!rvalid) @(posedge aclk);
      rd = rdata;
      rs = rresp;
      rready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic cap_chk(input logic e);
      rdr(REG_STAT);
      check("capture", rd[1], e);
      wr(REG_STAT, 32'h3);
   endtask

   task automatic wait_irq();
      do @(posedge aclk); while (irq !== 1'b1);
   endtask

   initial begin
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      awaddr = '0;
      araddr = '0;
      wdata = '0;
      wstrb = 4'hf;
      n_fail = 0;
      checks = 0;
      aresetn = 1'b0;
      void'($urandom(32'h14e0));
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rdr(REG_MODE);
      check("mode reset", rd, MODE_RST);
      wr(REG_MODE, 32'hffff);
      rdr(REG_MODE);
      check("mode bits", rd, MODE_WMASK);
      d = $urandom_range(16'hffff);
      wr(REG_DATA, d);
      rdr(REG_DATA);
      check("data", rd, d);
      wr(6'h24, 32'h1);
      rdr(6'h24);
      check("unmapped", rs, RESP_SLVERR);
      wr(REG_MODE, 32'h0);
      wr(REG_TOE, 32'h0);
      wr(REG_TO, 32'h1);
      repeat (2) @(posedge aclk);
      check("pin set", pin_out, 1);
      wr(REG_TOE, 32'h1);
      wr(REG_TO, 32'h0);
      repeat (2) @(posedge aclk);
      check("pin kept", pin_out, 1);
      wr(REG_MASK, 32'h3);
      wr(REG_DATA, 32'h18ff);
      for (int i = 0; i < 2; i++) begin
         wr(REG_STOP, 32'h1);
         wr(REG_STAT, 32'h3);
         n = pin_out;
         wr(REG_MODE, i);
         wr(REG_START, 32'h1);
         repeat (4) @(posedge aclk);
         check("start irq", irq, i);
         check("start toggle", pin_out ^ n, i);
      end
      wr(REG_STAT, 32'h3);
      wait_irq();
      t1 = $time;
      wr(REG_STAT, 32'h1);
      wait_irq();
      check("period", ($time - t1) / 4, 6400);
      wr(REG_MASK, 32'h0);
      check("masked", irq, 0);
      wr(REG_MASK, 32'h3);
      repeat (2) @(posedge aclk);
      check("unmasked", irq, 1);
      wr(REG_STAT, 32'h1);
      repeat (2) @(posedge aclk);
      check("cleared", irq, 0);
      wr(REG_STOP, 32'h0);
      rdr(REG_CNT);
      n = rd;
      rdr(REG_CNT);
      check("running", rd != n, 1);
      wr(REG_STOP, 32'h1);
      rdr(REG_CNT);
      n = rd;
      rdr(REG_CNT);
      check("halted", rd, n);
      d = $urandom_range(200, 20);
      wr(REG_DATA, d);
      wr(REG_MODE, 32'h1046);
      wr(REG_START, 32'h1);
      n = $urandom_range(8, 1);
      repeat (n) pins_u.pulse();
      rdr(REG_CNT);
      check("events", rd, d - n);
      foreach (trg[i]) begin
         wr(REG_STOP, 32'h1);
         wr(REG_MODE, 32'h0044 | (32'(trg[i]) << 8));
         wr(REG_START, 32'h1);
         wr(REG_STAT, 32'h3);
         pins_u.drive(1'b1);
         cap_chk(trg[i] == 3'h1 || trg[i] == 3'h2);
         pins_u.drive(1'b0);
         cap_chk(trg[i] == 3'h2);
         pins_u.mpulse();
         cap_chk(trg[i] == 3'h4);
      end
      wr(REG_STOP, 32'h1);
      wr(REG_DATA, 32'h40);
      for (int i = 0; i < 2; i++) begin
         wr(REG_MODE, i ? 32'h014c : 32'h0149);
         wr(REG_STAT, 32'h3);
         wr(REG_START, 32'h1);
         pins_u.drive(1'b1);
         rdr(REG_STAT);
         check("one-count start", rd[0], 0);
         pins_u.drive(1'b0);
         pins_u.drive(1'b1);
         rdr(REG_STAT);
         check("retrigger", rd[0], !i);
         pins_u.drive(1'b0);
         wr(REG_STOP, 32'h1);
      end
      give_verdict();
   end
endmodule

// *** bench/tcmo_channel_properties.sv ***
/*
 Checker for the timer channel ports: bus handshakes, reset levels,
 output pin writes and interrupt masking.
 Assumes the bench offers write address and data together.
*/
module tcmo_channel_properties
   import tcmo_pkg::*;
(
   // Clock and reset
   input wire logic              aclk,
   input wire logic              aresetn,
   // Register bus
   input wire logic              awvalid,
   input wire logic              awready,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic              wvalid,
   input wire logic              wready,
   input wire logic [31:0]       wdata,
   input wire logic [3:0]        wstrb,
   input wire logic              bvalid,
   input wire logic              bready,
   input wire logic [1:0]        bresp,
   input wire logic              arvalid,
   input wire logic              arready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic              rvalid,
   input wire logic              rready,
   input wire logic [31:0]       rdata,
   input wire logic [1:0]        rresp,
   // Pins
   input wire logic              timer_input_pin,
   input wire logic              master_irq,
   input wire logic              timer_output_pin,
   input wire logic              irq
);
   timeunit 1ns;
   timeprecision 1ps;

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   logic wr_take;
   logic toe_r;
   assign wr_take = awvalid && awready && wvalid && wready;

   // Output enable as last written
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         toe_r <= 1'b0;
      end else if (wr_take && awaddr == REG_TOE && wstrb[0]) begin
         toe_r <= wdata[0];
      end
   end

   a_reset_quiet: assert property (disable iff (1'b0)
      !aresetn |=> !irq && !timer_output_pin && !bvalid && !rvalid)
      else $error("outputs active after reset");
   a_write_answer: assert property (wr_take |=> !bvalid ##1 bvalid)
      else $error("write answer late or early");
   a_read_answer: assert property (arvalid && arready |=> rvalid)
      else $error("read answer missing");
   a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped");
   a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data dropped");
   a_write_free: assert property (bvalid && bready |=> !bvalid && awready && wready)
      else $error("write channel not freed");
   a_read_busy: assert property (rvalid |-> !arready)
      else $error("read accepted while busy");
   a_write_err: assert property (wr_take && awaddr > REG_MASK |-> ##2 bresp == RESP_SLVERR)
      else $error("unmapped write not refused");
   a_pin_write: assert property (
      wr_take && awaddr == REG_TO && wstrb[0] && !toe_r
      |-> ##3 timer_output_pin == $past(wdata[0], 3))
      else $error("output pin ignores write");
   a_mask_quiet: assert property (
      wr_take && awaddr == REG_MASK && wstrb[0] && wdata[1:0] == 2'h0 |-> ##3 !irq)
      else $error("masked interrupt raised");
endmodule

bind tcmo_channel tcmo_channel_properties chk_u (
   .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
   .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
   .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
   .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
   .rdata(rdata), .rresp(rresp), .timer_input_pin(timer_input_pin),
   .master_irq(master_irq), .timer_output_pin(timer_output_pin), .irq(irq)
);

// *** bench/tcmo_pins_model.sv ***
/*
 Far side of the channel: timer input pin and master channel interrupt.
 Assumes callers enter its tasks just after a clock edge.
*/
module tcmo_pins_model (
   // Clock
   input wire logic aclk,
   // Pins
   output logic     timer_input_pin,
   output logic     master_irq,
   input wire logic timer_output_pin
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      timer_input_pin = 1'b0;
      master_irq = 1'b0;
   end

   // Level held long enough for the edge detector
   task automatic drive(input logic v);
      @(posedge aclk);
      timer_input_pin <= v;
      repeat (4) @(posedge aclk);
   endtask

   task automatic pulse();
      drive(1'b1);
      drive(1'b0);
   endtask

   task automatic mpulse();
      @(posedge aclk);
      master_irq <= 1'b1;
      @(posedge aclk);
      master_irq <= 1'b0;
      repeat (4) @(posedge aclk);
   endtask
endmodule

// *** core/tcmo_channel.sv ***
/*
 One 16-bit timer channel with AXI4-Lite registers, a timer input pin,
 a timer output pin and one level interrupt.
 Assumes all inputs are synchronous to aclk; the master channel interrupt
 arrives as a one-cycle pulse on master_irq.
*/
// Summary of operation
// - Count clock is timer input valid edges when source bit set, else prescaled clock.
// - The selected count clock drives counter, output toggling and interrupt events.
// - Trigger code 000: only the software start may start the channel.
// - Trigger code 001: configured input edge is both start and capture trigger.
// - Trigger code 010: both input edges are start and capture triggers.
// - Trigger code 100: master channel interrupt is the trigger; other codes inert.
// - Mode codes 000, 010, 011, 100, 110 select mode and direction; others inert.
// - Interval or capture: start option 1 raises interrupt and toggles output at start.
// - One-count: start option 1 retriggers with interrupt, 0 ignores triggers while counting.
// - Capture one-count: no start interrupt or toggle; triggers while counting ignored.
// - Timer output pin follows the output value bit.
// - Output enable 0: timer leaves output bit alone, software writes take effect.
// - Output enable 1: timer toggles output bit, software writes ignored.
// - Writing 1 to the stop trigger halts counting; writing 0 does nothing.
module tcmo_channel
   import tcmo_pkg::*;
(
   // Clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // AXI4-Lite write
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              wvalid,
   output logic                   wready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   output logic                   bvalid,
   input  wire logic              bready,
   output logic [1:0]             bresp,
   // AXI4-Lite read
   input  wire logic              arvalid,
   output logic                   arready,
   input  wire logic [ADDR_W-1:0] araddr,
   output logic                   rvalid,
   input  wire logic              rready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   // Timer pins
   input  wire logic              timer_input_pin,
   input  wire logic              master_irq,
   output logic                   timer_output_pin,
   // Interrupt
   output logic                   irq
);
   tcmo_mode_t        mode_r;
   tcmo_state_t       state_r;
   tcmo_state_t       state_nxt;
   logic [15:0]       data_r;
   logic [15:0]       cnt_r;
   logic [15:0]       cnt_nxt;
   logic              to_r;
   logic              toe_r;
   logic              ti_prev_r;
   logic [2:0]        pre_r;
   logic [STAT_W-1:0] stat_r;
   logic [STAT_W-1:0] mask_r;
   logic [STAT_W-1:0] stat_set;
   logic [STAT_W-1:0] stat_nxt;
   logic              irq_r;
   logic              awready_r;
   logic              wready_r;
   logic              bvalid_r;
   logic              arready_r;
   logic              rvalid_r;
   logic [ADDR_W-1:0] awaddr_r;
   logic [31:0]       wdata_r;
   logic [31:0]       rdata_r;
   logic [3:0]        wstrb_r;
   logic [1:0]        bresp_r;
   logic [1:0]        rresp_r;
   logic              tgl;
   logic              cap_now;

   // Register write decode
   wire        wr_go     = ~awready_r & ~wready_r & ~bvalid_r;
   wire [15:0] wmask     = {{8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
   wire [15:0] wval      = wdata_r[15:0];
   wire        hit_mode  = wr_go & (awaddr_r == REG_MODE);
   wire        hit_data  = wr_go & (awaddr_r == REG_DATA);
   wire        hit_to    = wr_go & (awaddr_r == REG_TO) & wstrb_r[0];
   wire        hit_toe   = wr_go & (awaddr_r == REG_TOE) & wstrb_r[0];
   wire        hit_start = wr_go & (awaddr_r == REG_START) & wstrb_r[0];
   wire        hit_stop  = wr_go & (awaddr_r == REG_STOP) & wstrb_r[0];
   wire        hit_stat  = wr_go & (awaddr_r == REG_STAT) & wstrb_r[0];
   wire        hit_mask  = wr_go & (awaddr_r == REG_MASK) & wstrb_r[0];
   wire        wr_ok     = (awaddr_r <= REG_MASK) & (awaddr_r[1:0] == 2'h0);
   wire        soft_start = hit_start & wdata_r[0];
   wire        stop_now   = hit_stop & wdata_r[0];

   // Timer input edges
   wire ti_rise  = timer_input_pin & ~ti_prev_r;
   wire ti_fall  = ~timer_input_pin & ti_prev_r;
   wire cis_rise = (mode_r.cis == EDGE_RISE);
   wire cis_both = (mode_r.cis == EDGE_BOTH);
   wire ti_valid = cis_rise ? ti_rise :
                   cis_both ? (ti_rise | ti_fall) : ti_fall;

   // Count clock selection
   wire       cks_div1 = (mode_r.cks == 2'h0);
   wire       cks_div2 = (mode_r.cks == 2'h1);
   wire       cks_div4 = (mode_r.cks == 2'h2);
   wire [2:0] pre_mask = cks_div1 ? PRE_MASK0 :
                         cks_div2 ? PRE_MASK1 :
                         cks_div4 ? PRE_MASK2 : PRE_MASK3;
   wire pre_tick = (pre_r & pre_mask) == pre_mask;
   wire cnt_tick = mode_r.ccs ? ti_valid : pre_tick;

   // Hardware trigger source
   wire trg_soft   = (mode_r.sts == TRG_SOFT);
   wire trg_edge   = (mode_r.sts == TRG_EDGE);
   wire trg_both   = (mode_r.sts == TRG_BOTH);
   wire trg_master = (mode_r.sts == TRG_MASTER);
   wire hw_trig    = trg_edge   ? ti_valid :
                     trg_both   ? (ti_rise | ti_fall) :
                     trg_master ? master_irq : 1'b0;

   // Mode decode
   wire [2:0] md          = mode_r.md;
   wire       md_interval = (md == MD_INTERVAL);
   wire       md_capture  = (md == MD_CAPTURE);
   wire       md_onecnt   = (md == MD_ONECNT);
   wire       md_capone   = (md == MD_CAPONE);
   wire       one_md      = md_onecnt | md_capone;
   wire       up_md       = md_capture | md_capone;
   wire       st_opt      = mode_r.md0 & (md_interval | md_capture);
   wire       retrig      = mode_r.md0 & md_onecnt;
   wire       counting    = (state_r == ST_COUNT);
   wire       trig_in     = trg_soft ? soft_start :
                            ((state_r != ST_IDLE) & hw_trig);
   wire       start_now   = one_md ? (trig_in & (~counting | retrig)) : soft_start;
   // One-count with a hardware trigger: software start only arms
   wire       arm_now     = one_md & ~trg_soft & soft_start & (state_r == ST_IDLE);

   // Counting state machine
   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      stat_set  = '0;
      tgl       = 1'b0;
      cap_now   = 1'b0;
      // Stop wins over any start
      if (stop_now) begin
         state_nxt = ST_IDLE;
      end else if (start_now) begin
         state_nxt = ST_COUNT;
         cnt_nxt   = up_md ? 16'h0000 : data_r;
         stat_set[STAT_TMR] = st_opt | (counting & retrig);
         tgl       = st_opt;
      end else if (arm_now) begin
         state_nxt = ST_ARMED;
      end else if (counting & md_capture & hw_trig) begin
         // Capture restarts the up-count from zero
         cap_now   = 1'b1;
         cnt_nxt   = 16'h0000;
         stat_set[STAT_CAP] = 1'b1;
         stat_set[STAT_TMR] = 1'b1;
      end else if (counting & cnt_tick) begin
         case (md)
            // Event counter shares the interval reload path
            MD_INTERVAL, MD_EVENT: begin
               if (cnt_r == 16'h0000) begin
                  cnt_nxt = data_r;
                  stat_set[STAT_TMR] = 1'b1;
                  tgl = 1'b1;
               end else begin
                  cnt_nxt = cnt_r - 16'h0001;
               end
            end
            MD_ONECNT: begin
               if (cnt_r == 16'h0000) begin
                  state_nxt = ST_ARMED;
                  stat_set[STAT_TMR] = 1'b1;
                  tgl = 1'b1;
               end else begin
                  cnt_nxt = cnt_r - 16'h0001;
               end
            end
            MD_CAPTURE: cnt_nxt = cnt_r + 16'h0001;
            MD_CAPONE: begin
               if (cnt_r == data_r) begin
                  state_nxt = ST_ARMED;
                  stat_set[STAT_TMR] = 1'b1;
                  tgl = 1'b1;
               end else begin
                  cnt_nxt = cnt_r + 16'h0001;
               end
            end
            default: cnt_nxt = cnt_r;
         endcase
      end
   end

   // Sticky status bits: a set in the same cycle as a clear wins
   for (genvar b = 0; b < STAT_W; b++) begin : g_stat
      wire clr_b = hit_stat & wdata_r[b];
      assign stat_nxt[b] = stat_set[b] | (stat_r[b] & ~clr_b);
   end

   // Counter and state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r <= ST_IDLE;
         cnt_r   <= 16'h0000;
      end else begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
      end
   end

   // Prescaler and input edge history
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pre_r     <= 3'h0;
         ti_prev_r <= 1'b0;
      end else begin
         pre_r     <= pre_r + 3'h1;
         ti_prev_r <= timer_input_pin;
      end
   end

   // Status and interrupt
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stat_r <= '0;
         irq_r  <= 1'b0;
      end else begin
         stat_r <= stat_nxt;
         irq_r  <= |(stat_nxt & mask_r);
      end
   end

   // Mode register
   always_ff @(posedge aclk) begin
      if (!aresetn)
         mode_r <= tcmo_mode_t'(MODE_RST);
      else if (hit_mode)
         mode_r <= tcmo_mode_t'(((mode_r & ~wmask) | (wval & wmask)) & MODE_WMASK);
   end

   // Reload data: a capture wins over a software write
   always_ff @(posedge aclk) begin
      if (!aresetn)
         data_r <= DATA_RST;
      else if (cap_now)
         data_r <= cnt_r;
      else if (hit_data)
         data_r <= (data_r & ~wmask) | (wval & wmask);
   end

   // Interrupt mask and output enable
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mask_r <= '0;
         toe_r  <= 1'b0;
      end else begin
         if (hit_mask)
            mask_r <= wdata_r[STAT_W-1:0];
         if (hit_toe)
            toe_r <= wdata_r[0];
      end
   end

   // Output value bit
   always_ff @(posedge aclk) begin
      if (!aresetn)
         to_r <= 1'b0;
      else if (toe_r)
         to_r <= to_r ^ tgl;
      else if (hit_to)
         to_r <= wdata_r[0];
   end

   // Read data selection
   wire rd_mode  = (araddr == REG_MODE);
   wire rd_data  = (araddr == REG_DATA);
   wire rd_to    = (araddr == REG_TO);
   wire rd_toe   = (araddr == REG_TOE);
   wire rd_start = (araddr == REG_START);
   wire rd_cnt   = (araddr == REG_CNT);
   wire rd_stat  = (araddr == REG_STAT);
   wire rd_mask  = (araddr == REG_MASK);
   wire [15:0] rd_val =
      rd_mode  ? 16'(mode_r) :
      rd_data  ? data_r :
      rd_to    ? {15'h0000, to_r} :
      rd_toe   ? {15'h0000, toe_r} :
      rd_start ? {14'h0000, counting, state_r != ST_IDLE} :
      rd_cnt   ? cnt_r :
      rd_stat  ? {14'h0000, stat_r} :
      rd_mask  ? {14'h0000, mask_r} : 16'h0000;
   wire rd_ok = (araddr <= REG_MASK) & (araddr[1:0] == 2'h0);

   // AXI4-Lite write address, free again after the response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_r <= 1'b1;
         awaddr_r  <= '0;
      end else if (awvalid & awready_r) begin
         awready_r <= 1'b0;
         awaddr_r  <= awaddr;
      end else if (bvalid_r & bready) begin
         awready_r <= 1'b1;
      end
   end

   // AXI4-Lite write data
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wready_r <= 1'b1;
         wdata_r  <= 32'h0000_0000;
         wstrb_r  <= 4'h0;
      end else if (wvalid & wready_r) begin
         wready_r <= 1'b0;
         wdata_r  <= wdata;
         wstrb_r  <= wstrb;
      end else if (bvalid_r & bready) begin
         wready_r <= 1'b1;
      end
   end

   // AXI4-Lite write response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_r <= 1'b0;
         bresp_r  <= RESP_OKAY;
      end else if (wr_go) begin
         bvalid_r <= 1'b1;
         bresp_r  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_r & bready) begin
         bvalid_r <= 1'b0;
      end
   end

   // AXI4-Lite read address
   always_ff @(posedge aclk) begin
      if (!aresetn)
         arready_r <= 1'b1;
      else if (arvalid & arready_r)
         arready_r <= 1'b0;
      else if (rvalid_r & rready)
         arready_r <= 1'b1;
   end

   // AXI4-Lite read data, answered at the edge that takes the address
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0;
         rdata_r  <= 32'h0000_0000;
         rresp_r  <= RESP_OKAY;
      end else if (arvalid & arready_r) begin
         rvalid_r <= 1'b1;
         rdata_r  <= {16'h0000, rd_val};
         rresp_r  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_r & rready) begin
         rvalid_r <= 1'b0;
      end
   end

   assign awready          = awready_r;
   assign wready           = wready_r;
   assign bvalid           = bvalid_r;
   assign bresp            = bresp_r;
   assign arready          = arready_r;
   assign rvalid           = rvalid_r;
   assign rdata            = rdata_r;
   assign rresp            = rresp_r;
   assign timer_output_pin = to_r;
   assign irq              = irq_r;
endmodule

// *** core/tcmo_pkg.sv ***
/*
 Constants, register map and types for one 16-bit timer channel.
 Assumes one clock (aclk) and an AXI4-Lite register port with 6 address bits.
*/
package tcmo_pkg;
   // Register byte offsets
   localparam int unsigned ADDR_W          = 6;
   localparam logic [5:0]  REG_MODE        = 6'h00;
   localparam logic [5:0]  REG_DATA        = 6'h04;
   localparam logic [5:0]  REG_TO          = 6'h08;
   localparam logic [5:0]  REG_TOE         = 6'h0c;
   localparam logic [5:0]  REG_START       = 6'h10;
   localparam logic [5:0]  REG_STOP        = 6'h14;
   localparam logic [5:0]  REG_CNT         = 6'h18;
   localparam logic [5:0]  REG_STAT        = 6'h1c;
   localparam logic [5:0]  REG_MASK        = 6'h20;

   // Reset values and mode register write mask
   localparam logic [15:0] MODE_RST        = 16'h0000;
   localparam logic [15:0] DATA_RST        = 16'h0000;
   localparam logic [15:0] MODE_WMASK      = 16'hd7cf;

   // Operation modes (bits 3..1 of the mode register)
   localparam logic [2:0]  MD_INTERVAL     = 3'h0;
   localparam logic [2:0]  MD_CAPTURE      = 3'h2;
   localparam logic [2:0]  MD_EVENT        = 3'h3;
   localparam logic [2:0]  MD_ONECNT       = 3'h4;
   localparam logic [2:0]  MD_CAPONE       = 3'h6;

   // Start / capture trigger sources
   localparam logic [2:0]  TRG_SOFT        = 3'h0;
   localparam logic [2:0]  TRG_EDGE        = 3'h1;
   localparam logic [2:0]  TRG_BOTH        = 3'h2;
   localparam logic [2:0]  TRG_MASTER      = 3'h4;

   // Valid edge of the timer input
   localparam logic [1:0]  EDGE_FALL       = 2'h0;
   localparam logic [1:0]  EDGE_RISE       = 2'h1;
   localparam logic [1:0]  EDGE_BOTH       = 2'h2;

   // Operation clock prescaler masks, divide by 1, 2, 4, 8
   localparam logic [2:0]  PRE_MASK0       = 3'h0;
   localparam logic [2:0]  PRE_MASK1       = 3'h1;
   localparam logic [2:0]  PRE_MASK2       = 3'h3;
   localparam logic [2:0]  PRE_MASK3       = 3'h7;

   // Interrupt status bits
   localparam int unsigned STAT_W          = 2;
   localparam int unsigned STAT_TMR        = 0;
   localparam int unsigned STAT_CAP        = 1;

   localparam logic [1:0]  RESP_OKAY       = 2'h0;
   localparam logic [1:0]  RESP_SLVERR     = 2'h2;

   typedef struct packed {
      logic [1:0] cks;
      logic       rsv13;
      logic       ccs;
      logic       rsv11;
      logic [2:0] sts;
      logic [1:0] cis;
      logic [1:0] rsv5;
      logic [2:0] md;
      logic       md0;
   } tcmo_mode_t;

   typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_COUNT} tcmo_state_t;
endpackage
